//--- hdl/umlb_pkg.sv
package umlb_pkg;

   // Register offsets on the byte-wide register port.
   localparam logic [2:0] ADR_DATA  = 3'h0;
   localparam logic [2:0] ADR_IER   = 3'h1;
   localparam logic [2:0] ADR_FCR   = 3'h2;
   localparam logic [2:0] ADR_LCR   = 3'h3;
   localparam logic [2:0] ADR_MCR   = 3'h4;
   localparam logic [2:0] ADR_LSR   = 3'h5;
   localparam logic [2:0] ADR_MSR   = 3'h6;
   localparam logic [2:0] ADR_SPARE = 3'h7;

   // Modem control fields.
   localparam int MCR_TERM = 0;
   localparam int MCR_SEND = 1;
   localparam int MCR_FLAG = 2;
   localparam int MCR_GATE = 3;
   localparam int MCR_LOOP = 4;
   localparam logic [7:0] MCR_MASK = 8'h1F;

   // Line configuration and FIFO control fields.
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_EVEN   = 4;
   localparam int LCR_BREAK  = 6;
   localparam int LCR_DIVISOR_ACCESS_BIT   = 7;
   localparam int FCR_EN     = 0;
   localparam int FCR_RX_CLR = 1;

   // Irq enable fields.
   localparam int IER_RXD = 0;
   localparam int IER_THR = 1;
   localparam int IER_LSR = 2;
   localparam int IER_MSR = 3;

   // Reference clock for the divider: crystal over prescale, made from the core clock.
   localparam int XTAL_MHZ = 24;
   localparam int XTAL_DIV = 13;
   localparam int CORE_MHZ = 250;
   localparam logic [11:0] REF_STEP = 12'(XTAL_MHZ);
   localparam logic [11:0] REF_WRAP = 12'(XTAL_DIV * CORE_MHZ);
   localparam logic [11:0] REF_HALF = 12'(XTAL_DIV * CORE_MHZ / 2);

   localparam logic [3:0]  OVS_LAST  = 4'hF;
   localparam logic [3:0]  HALF_BIT  = 4'h7;
   localparam logic [2:0]  LAST_BIT  = 3'h7;
   localparam logic [4:0]  FIFO_CAP  = 5'h10;
   localparam logic [4:0]  HOLD_CAP  = 5'h01;
   localparam logic [7:0]  LSR_RESET = 8'h60;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} umlb_rx_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} umlb_tx_t;

endpackage

//--- hdl/umlb_uart.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module umlb_uart
   import umlb_pkg::*;
(
   input  wire logic       CORE_CLK,
   input  wire logic       RESETN,
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WR_DATA,
   input  wire logic       WR_EN,
   input  wire logic       RD_EN,
   output logic      [7:0] RD_DATA,
   input  wire logic       RXD,
   output logic            TXD,
   output logic            TERM_READY_PIN_N,
   output logic            SEND_REQUEST_PIN_N,
   input  wire logic       CLEAR_TO_SEND_PIN_N,
   input  wire logic       SET_READY_PIN_N,
   input  wire logic       RING_PIN_N,
   input  wire logic       CARRIER_PIN_N,
   output logic            IRQ_O,
   output logic            IRQ_OE,
   output logic            BAUD_OUT
);

   logic [7:0]  mcr_q, lcr_q, ier_q, spare_q, dll_q, dlh_q;
   logic        fifo_en_q;
   logic [4:0]  pin_s1_q, pin_s2_q;
   logic [11:0] acc_q;
   logic [15:0] bcnt_q;
   logic        baud_q;
   logic [3:0]  msr_prev_q, delta_q;
   logic        oe_q, pe_q, fe_q, bi_q, ferr_q;
   logic [10:0] mem_q [16];
   logic [3:0]  wp_q, rp_q;
   logic [4:0]  cnt_q, ecnt_q;
   umlb_rx_t    rx_st_q;
   logic [3:0]  rx_sc_q;
   logic [2:0]  rx_bit_q;
   logic [7:0]  rx_sh_q;
   logic        rx_zero_q, rx_pe_q;
   umlb_tx_t    tx_st_q;
   logic [3:0]  tx_sc_q;
   logic [2:0]  tx_bit_q;
   logic [7:0]  tx_sh_q, thr_q;
   logic        thr_full_q, tx_line_q;
   logic [7:0]  rd_q;
   logic        txd_q, term_q, send_q, irq_q, irq_oe_q;

   // Bus decode.
   wire divisor_access_bit    = lcr_q[LCR_DIVISOR_ACCESS_BIT];
   wire loop    = mcr_q[MCR_LOOP];
   wire wr_data = WR_EN && (ADDR == ADR_DATA) && !divisor_access_bit;
   wire wr_dll  = WR_EN && (ADDR == ADR_DATA) && divisor_access_bit;
   wire wr_dlh  = WR_EN && (ADDR == ADR_IER) && divisor_access_bit;
   wire wr_ier  = WR_EN && (ADDR == ADR_IER) && !divisor_access_bit;
   wire wr_fcr  = WR_EN && (ADDR == ADR_FCR);
   wire rd_data = RD_EN && (ADDR == ADR_DATA) && !divisor_access_bit;
   wire rd_lsr  = RD_EN && (ADDR == ADR_LSR);
   wire rd_msr  = RD_EN && (ADDR == ADR_MSR);

   // The pins are asynchronous to the core; only the second stage is read.
   wire       rxd_pin = pin_s2_q[4];
   wire [3:0] mdm_n   = pin_s2_q[3:0];

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_s1_q <= 5'h1F;
         pin_s2_q <= 5'h1F;
      end else begin
         pin_s1_q <= {RXD, CARRIER_PIN_N, RING_PIN_N, SET_READY_PIN_N, CLEAR_TO_SEND_PIN_N};
         pin_s2_q <= pin_s1_q;
      end
   end

   // Reference tick: 24 MHz / 13 synthesised from the core clock by a phase accumulator.
   wire        ref_tick = (acc_q >= (REF_WRAP - REF_STEP));
   wire [11:0] acc_d    = ref_tick ? acc_q + REF_STEP - REF_WRAP : acc_q + REF_STEP;
   wire        ref_lvl  = (acc_q < REF_HALF);

   // Baud divider. A zero divisor acts as three.
   wire [15:0] div_w    = {wr_dlh ? WR_DATA : dlh_q, wr_dll ? WR_DATA : dll_q};
   wire [15:0] eff_w    = (div_w == 16'h0000) ? 16'h0003 : div_w;
   wire [15:0] eff_q    = ({dlh_q, dll_q} == 16'h0000) ? 16'h0003 : {dlh_q, dll_q};
   wire        tick16   = ref_tick && (bcnt_q == 16'h0000);
   wire [15:0] bcnt_d   = (wr_dll || wr_dlh) ? eff_w - 16'h0001 :
                          tick16 ? eff_q - 16'h0001 :
                          ref_tick ? bcnt_q - 16'h0001 : bcnt_q;
   wire        baud_d   = (eff_q == 16'h0001) ? !ref_lvl :
                          (eff_q == 16'h0002) ? (bcnt_q == 16'h0000) :
                          (bcnt_q < eff_q - 16'h0002);

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_q  <= 12'h000;
         bcnt_q <= 16'h0000;
         baud_q <= 1'b0;
      end else begin
         acc_q  <= acc_d;
         bcnt_q <= bcnt_d;
         baud_q <= baud_d;
      end
   end

   // Software registers.
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         mcr_q     <= 8'h00;
         lcr_q     <= 8'h00;
         ier_q     <= 8'h00;
         spare_q   <= 8'h00;
         dll_q     <= 8'h00;
         dlh_q     <= 8'h00;
         fifo_en_q <= 1'b0;
      end else begin
         if (WR_EN && ADDR == ADR_MCR)   mcr_q   <= WR_DATA & MCR_MASK;
         if (WR_EN && ADDR == ADR_LCR)   lcr_q   <= WR_DATA;
         if (WR_EN && ADDR == ADR_SPARE) spare_q <= WR_DATA;
         if (wr_ier) ier_q <= {4'h0, WR_DATA[3:0]};
         if (wr_dll) dll_q <= WR_DATA;
         if (wr_dlh) dlh_q <= WR_DATA;
         if (wr_fcr) fifo_en_q <= WR_DATA[FCR_EN];
      end
   end

   // Modem status. In loopback the control bits stand in for the inputs.
   wire [3:0] mstat = loop ? {mcr_q[MCR_GATE], mcr_q[MCR_FLAG],
                              mcr_q[MCR_TERM], mcr_q[MCR_SEND]} : ~mdm_n;
   wire [3:0] dset  = {mstat[3] ^ msr_prev_q[3], msr_prev_q[2] & !mstat[2],
                       mstat[1] ^ msr_prev_q[1], mstat[0] ^ msr_prev_q[0]};

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         msr_prev_q <= 4'h0;
         delta_q    <= 4'h0;
      end else begin
         msr_prev_q <= mstat;
         delta_q    <= dset | (rd_msr ? 4'h0 : delta_q);
      end
   end

   // Transmitter. The shift output also feeds the receiver in loopback.
   wire       par_en   = lcr_q[LCR_PAR_EN];
   wire       tx_xfer  = (tx_st_q == TX_IDLE) && thr_full_q;
   wire       tx_end   = tick16 && (tx_sc_q == OVS_LAST);
   wire       ser_out  = lcr_q[LCR_BREAK] ? 1'b0 : tx_line_q;
   wire       tx_par   = lcr_q[LCR_EVEN] ? ^tx_sh_q : ~^tx_sh_q;
   wire       thr_empty = !thr_full_q;
   wire       tx_empty  = !thr_full_q && (tx_st_q == TX_IDLE);

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         thr_q      <= 8'h00;
         thr_full_q <= 1'b0;
      end else begin
         if (wr_data) thr_q <= WR_DATA;
         thr_full_q <= wr_data || (thr_full_q && !tx_xfer);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_st_q   <= TX_IDLE;
         tx_sc_q   <= 4'h0;
         tx_bit_q  <= 3'h0;
         tx_sh_q   <= 8'h00;
         tx_line_q <= 1'b1;
      end else begin
         if (tick16) tx_sc_q <= tx_sc_q + 4'h1;
         case (tx_st_q)
            TX_IDLE: begin
               tx_line_q <= 1'b1;
               if (tx_xfer) begin
                  tx_sh_q   <= thr_q;
                  tx_st_q   <= TX_START;
                  tx_sc_q   <= 4'h0;
                  tx_line_q <= 1'b0;
               end
            end
            TX_START: begin
               if (tx_end) begin
                  tx_st_q   <= TX_DATA;
                  tx_bit_q  <= 3'h0;
                  tx_line_q <= tx_sh_q[0];
               end
            end
            TX_DATA: begin
               if (tx_end) begin
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == LAST_BIT) begin
                     tx_st_q   <= par_en ? TX_PAR : TX_STOP;
                     tx_line_q <= par_en ? tx_par : 1'b1;
                  end else begin
                     tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
                     tx_line_q <= tx_sh_q[1];
                  end
               end
            end
            TX_PAR: begin
               if (tx_end) begin
                  tx_st_q   <= TX_STOP;
                  tx_line_q <= 1'b1;
               end
            end
            TX_STOP: begin
               if (tx_end) tx_st_q <= TX_IDLE;
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // Receiver, sampling bit centres on the sixteen-times tick.
   wire       rx_in    = loop ? ser_out : rxd_pin;
   wire       rx_mid   = tick16 && (rx_sc_q == OVS_LAST);
   wire       rx_push  = (rx_st_q == RX_STOP) && rx_mid;
   wire       rx_brk   = rx_zero_q && !rx_in && !(par_en && rx_pe_q);
   wire       rx_fe    = !rx_in && !rx_brk;
   wire [2:0] push_err = {rx_brk, rx_fe, rx_pe_q && !rx_brk};
   wire [7:0] push_dat = rx_brk ? 8'h00 : rx_sh_q;
   wire       rx_pbit  = lcr_q[LCR_EVEN] ? ^rx_sh_q : ~^rx_sh_q;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_st_q   <= RX_IDLE;
         rx_sc_q   <= 4'h0;
         rx_bit_q  <= 3'h0;
         rx_sh_q   <= 8'h00;
         rx_zero_q <= 1'b0;
         rx_pe_q   <= 1'b0;
      end else begin
         if (tick16) rx_sc_q <= rx_sc_q + 4'h1;
         case (rx_st_q)
            RX_IDLE: begin
               rx_sc_q <= 4'h0;
               if (tick16 && !rx_in) rx_st_q <= RX_START;
            end
            RX_START: begin
               if (tick16 && rx_sc_q == HALF_BIT) begin
                  rx_sc_q   <= 4'h0;
                  rx_bit_q  <= 3'h0;
                  rx_zero_q <= 1'b1;
                  rx_pe_q   <= 1'b0;
                  rx_st_q   <= rx_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_mid) begin
                  rx_sh_q   <= {rx_in, rx_sh_q[7:1]};
                  rx_zero_q <= rx_zero_q && !rx_in;
                  rx_bit_q  <= rx_bit_q + 3'h1;
                  if (rx_bit_q == LAST_BIT) rx_st_q <= par_en ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               if (rx_mid) begin
                  rx_pe_q   <= (rx_in != rx_pbit);
                  rx_zero_q <= rx_zero_q && !rx_in;
                  rx_st_q   <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_mid) begin
                  rx_sc_q <= 4'h0;
                  // After a framing error the low stop is taken as the next start bit.
                  rx_st_q <= rx_brk ? RX_BRK : rx_fe ? RX_START : RX_IDLE;
               end
            end
            RX_BRK: begin
               // The line must stay high half a bit before a new start is hunted.
               if (tick16 && !rx_in) rx_sc_q <= 4'h0;
               if (tick16 && rx_in && rx_sc_q == HALF_BIT) rx_st_q <= RX_IDLE;
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // Receive store: sixteen entries in FIFO mode, one holding entry otherwise.
   wire [4:0]  cap      = fifo_en_q ? FIFO_CAP : HOLD_CAP;
   wire        rx_pop   = rd_data && (cnt_q != 5'h00);
   wire        full     = (cnt_q >= cap);
   wire        ovr_evt  = rx_push && full && !rx_pop;
   wire        push_ok  = rx_push && !ovr_evt;
   wire        hold_ovw = ovr_evt && !fifo_en_q;
   wire        flush    = wr_fcr && (WR_DATA[FCR_RX_CLR] || WR_DATA[FCR_EN] != fifo_en_q);
   wire [3:0]  rp_nx    = rp_q + 4'h1;
   wire [2:0]  head_err = mem_q[rp_q][10:8];
   wire        next_mem = rx_pop && (cnt_q > 5'h01);
   wire        head_new = next_mem || (push_ok && (cnt_q == 5'h00 || rx_pop)) || hold_ovw;
   wire [2:0]  new_err  = next_mem ? mem_q[rp_nx][10:8] : push_err;
   wire [3:0]  wr_idx   = hold_ovw ? rp_q : wp_q;
   wire        err_in   = push_ok && (push_err != 3'h0);
   wire        err_out  = rx_pop && (head_err != 3'h0);

   always_ff @(posedge CORE_CLK) begin
      if (push_ok || hold_ovw) mem_q[wr_idx] <= {push_err, push_dat};
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wp_q   <= 4'h0;
         rp_q   <= 4'h0;
         cnt_q  <= 5'h00;
         ecnt_q <= 5'h00;
      end else if (flush) begin
         wp_q   <= 4'h0;
         rp_q   <= 4'h0;
         cnt_q  <= 5'h00;
         ecnt_q <= 5'h00;
      end else begin
         if (push_ok) wp_q <= wp_q + 4'h1;
         if (rx_pop)  rp_q <= rp_nx;
         cnt_q  <= cnt_q + {4'h0, push_ok} - {4'h0, rx_pop};
         ecnt_q <= ecnt_q + {4'h0, err_in} - {4'h0, err_out};
      end
   end

   // Error flags: a new event in the reading cycle survives the clear.
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         oe_q   <= 1'b0;
         pe_q   <= 1'b0;
         fe_q   <= 1'b0;
         bi_q   <= 1'b0;
         ferr_q <= 1'b0;
      end else begin
         oe_q   <= ovr_evt || (oe_q && !rd_lsr);
         pe_q   <= (head_new && new_err[0]) || (pe_q && !rd_lsr);
         fe_q   <= (head_new && new_err[1]) || (fe_q && !rd_lsr);
         bi_q   <= (head_new && new_err[2]) || (bi_q && !rd_lsr);
         ferr_q <= fifo_en_q && ((ecnt_q != 5'h00) || err_in || (ferr_q && !rd_lsr));
      end
   end

   wire [7:0] line_stat_reg = {ferr_q, tx_empty, thr_empty, bi_q, fe_q, pe_q, oe_q,
                     cnt_q != 5'h00};
   wire [7:0] modem_stat_reg = {mstat, delta_q};

   // Interrupt sources, each gated by its enable.
   wire irq_d = (ier_q[IER_RXD] && line_stat_reg[0]) ||
                (ier_q[IER_THR] && thr_empty) ||
                (ier_q[IER_LSR] && (line_stat_reg[4:1] != 4'h0)) ||
                (ier_q[IER_MSR] && (delta_q != 4'h0));

   wire [7:0] rd_mux = (ADDR == ADR_DATA)  ? (divisor_access_bit ? dll_q : mem_q[rp_q][7:0]) :
                       (ADDR == ADR_IER)   ? (divisor_access_bit ? dlh_q : ier_q) :
                       (ADDR == ADR_LCR)   ? lcr_q :
                       (ADDR == ADR_MCR)   ? mcr_q :
                       (ADDR == ADR_LSR)   ? line_stat_reg :
                       (ADDR == ADR_MSR)   ? modem_stat_reg :
                       (ADDR == ADR_SPARE) ? spare_q : 8'h00;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rd_q     <= 8'h00;
         txd_q    <= 1'b1;
         term_q   <= 1'b1;
         send_q   <= 1'b1;
         irq_q    <= 1'b0;
         irq_oe_q <= 1'b0;
      end else begin
         rd_q     <= RD_EN ? rd_mux : 8'h00;
         txd_q    <= loop ? 1'b1 : ser_out;
         term_q   <= loop ? 1'b1 : !mcr_q[MCR_TERM];
         send_q   <= loop ? 1'b1 : !mcr_q[MCR_SEND];
         irq_q    <= irq_d;
         irq_oe_q <= mcr_q[MCR_GATE];
      end
   end

   assign RD_DATA            = rd_q;
   assign TXD                = txd_q;
   assign TERM_READY_PIN_N   = term_q;
   assign SEND_REQUEST_PIN_N = send_q;
   assign IRQ_O              = irq_q;
   assign IRQ_OE             = irq_oe_q;
   assign BAUD_OUT           = baud_q;

   AST_TERM_PIN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      !mcr_q[MCR_LOOP] |=> (TERM_READY_PIN_N == !$past(mcr_q[MCR_TERM])))
      else $error("terminal-ready pin does not follow control bit");
   AST_MCR_ZERO: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (RD_EN && ADDR == ADR_MCR) |=> (RD_DATA[7:5] == 3'h0))
      else $error("control bits 5 to 7 read nonzero");
   AST_IRQ_GATE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (WR_EN && ADDR == ADR_MCR) |-> ##2 (IRQ_OE == $past(WR_DATA[MCR_GATE], 2)))
      else $error("interrupt enable does not follow gate bit");
   AST_LOOP_TXD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      mcr_q[MCR_LOOP] |=> TXD)
      else $error("serial output not marking in loopback");
   AST_LOOP_PINS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      mcr_q[MCR_LOOP] |=> (TERM_READY_PIN_N && SEND_REQUEST_PIN_N))
      else $error("modem pins not inactive in loopback");
   AST_DATA_READY: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (push_ok && !flush) |=> line_stat_reg[0])
      else $error("data ready not set after character");
   AST_OVR_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (rd_lsr && !ovr_evt) |=> !oe_q)
      else $error("overrun not cleared by status read");
   AST_THR_WRITE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      wr_data |=> !thr_empty && !tx_empty)
      else $error("holding empty still set after write");
   AST_SPARE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (WR_EN && ADDR == ADR_SPARE) ##1 !WR_EN ##1 (RD_EN && ADDR == ADR_SPARE && !WR_EN)
      |=> (RD_DATA == $past(WR_DATA, 3)))
      else $error("spare register read mismatch");
   AST_RELOAD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (wr_dll || wr_dlh) |=> (bcnt_q == eff_q - 16'h0001))
      else $error("baud counter not reloaded on divisor write");
   AST_MSR_LOOP: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (mcr_q[MCR_LOOP] && RD_EN && ADDR == ADR_MSR)
      |=> (RD_DATA[4] == $past(mcr_q[MCR_SEND])))
      else $error("loopback status bit 4 does not show send request");

endmodule

`default_nettype wire

//--- sim/uart_modem_line_status_baud_tb.sv
`timescale 1ns/100ps
`default_nettype none

module uart_modem_line_status_baud_tb;
   import umlb_pkg::*;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, txd, dtr_n, rts_n, cts_n, dsr_n, ri_n, dcd_n;
   logic rxd, irq, irq_oe, baud;
   logic [2:0] adr = 3'h0;
   logic [7:0] wd = 8'h00, rdd, d;
   logic [3:0] lines = 4'h0;
   int failures = 0, total_checks = 0, cyc = 0, hi, lo;
   always #2 clk = ~clk;
   umlb_modem modem (.assert_q(lines), .clear_to_send_n(cts_n), .set_ready_n(dsr_n),
      .ring_n(ri_n), .carrier_n(dcd_n), .rxd(rxd));
   umlb_uart dut (.CORE_CLK(clk), .RESETN(rstn), .ADDR(adr), .WR_DATA(wd), .WR_EN(wr),
      .RD_EN(rd), .RD_DATA(rdd), .RXD(rxd), .TXD(txd), .TERM_READY_PIN_N(dtr_n),
      .SEND_REQUEST_PIN_N(rts_n), .CLEAR_TO_SEND_PIN_N(cts_n), .SET_READY_PIN_N(dsr_n),
      .RING_PIN_N(ri_n), .CARRIER_PIN_N(dcd_n), .IRQ_O(irq), .IRQ_OE(irq_oe), .BAUD_OUT(baud));
   task automatic test_done;
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A generous ceiling; the two looped-back characters take about 45000 cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wreg(logic [2:0] a, logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1; adr <= a; wd <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      rd <= 1'b1; adr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdd;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk);
   endtask
   // Times one whole high phase and the low phase that follows it.
   task automatic measure;
      hi = 0; lo = 0;
      while (baud !== 1'b0) @(posedge clk);
      while (baud !== 1'b1) @(posedge clk);
      while (baud === 1'b1) begin hi++; @(posedge clk); end
      while (baud === 1'b0) begin lo++; @(posedge clk); end
   endtask
   task automatic divisor(logic [7:0] v);
      wreg(ADR_LCR, 8'h80); wreg(3'h0, v); wreg(3'h1, 8'h00); wreg(ADR_LCR, 8'h00);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rreg(ADR_LSR, d); chk("line_stat_reg", d, LSR_RESET);
      wreg(ADR_MCR, 8'h0B); idle(2);
      chk("pins", {irq_oe, dtr_n, rts_n}, 8'h04);
      wreg(ADR_MCR, 8'hFF); rreg(ADR_MCR, d); chk("modem_ctrl_reg", d, 8'h1F);
      idle(4); chk("loop pins", {txd, dtr_n, rts_n}, 8'h07);
      rreg(ADR_MSR, d); chk("loop status", d & 8'hF0, 8'hF0);
      wreg(ADR_MCR, 8'h10); idle(4);
      rreg(ADR_MSR, d); chk("loop deltas", d, 8'h0F);
      rreg(ADR_MSR, d); chk("deltas cleared", d, 8'h00);
      wreg(ADR_MCR, 8'h00); idle(4); rreg(ADR_MSR, d); wreg(ADR_IER, 8'h08);
      lines <= 4'h1; idle(5); chk("irq", {7'h0, irq}, 8'h01);
      rreg(ADR_MSR, d); chk("cts on", d, 8'h11);
      rreg(ADR_MSR, d); chk("cts held", d, 8'h10);
      chk("irq", {7'h0, irq}, 8'h00);
      lines <= 4'h5; idle(5); rreg(ADR_MSR, d); chk("ring on", d, 8'h50);
      lines <= 4'h1; idle(5); rreg(ADR_MSR, d); chk("ring end", d, 8'h14);
      wreg(ADR_SPARE, 8'hA5); rreg(ADR_SPARE, d); chk("spare_byte_reg", d, 8'hA5);
      divisor(8'h01); measure();
      chk("div1 period", 8'((hi + lo) inside {[133:138]}), 8'h01);
      // One character takes about 160 ticks of roughly 135 cycles at divisor 1.
      wreg(ADR_MCR, 8'h10); wreg(ADR_DATA, 8'h5A);
      rreg(ADR_LSR, d); chk("tx busy", d, 8'h20);
      idle(22500); rreg(ADR_LSR, d); chk("rx ready", d, 8'h61);
      rreg(ADR_DATA, d); chk("loop data", d, 8'h5A);
      rreg(ADR_LSR, d); chk("rx drained", d, 8'h60);
      wreg(ADR_IER, 8'h04); wreg(ADR_LCR, 8'h40); idle(22500);
      wreg(ADR_LCR, 8'h00); idle(1500);
      chk("irq", {7'h0, irq}, 8'h01);
      rreg(ADR_LSR, d); chk("break", d, 8'h71);
      rreg(ADR_DATA, d); chk("break char", d, 8'h00);
      rreg(ADR_LSR, d); chk("break cleared", d, 8'h60);
      chk("irq", {7'h0, irq}, 8'h00);
      divisor(8'h02); measure();
      chk("div2 duty", 8'(hi inside {[132:139]} && lo inside {[132:139]}), 8'h01);
      divisor(8'h03); measure();
      chk("div3 low", 8'(lo inside {[266:276]} && hi inside {[132:139]}), 8'h01);
      divisor(8'h00); measure();
      chk("div0 low", 8'(lo inside {[266:276]} && hi inside {[132:139]}), 8'h01);
      test_done();
   end
endmodule
`default_nettype wire

//--- sim/umlb_modem.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side data set; assert_q bits are cts, dsr, ring, carrier requested active.
module umlb_modem (
   input  wire logic [3:0] assert_q,
   output logic            clear_to_send_n,
   output logic            set_ready_n,
   output logic            ring_n,
   output logic            carrier_n,
   output logic            rxd
);
   assign clear_to_send_n = ~assert_q[0];
   assign set_ready_n     = ~assert_q[1];
   assign ring_n          = ~assert_q[2];
   assign carrier_n       = ~assert_q[3];
   // The line stays marking, so any restart after a break already has its idle time.
   assign rxd             = 1'b1;
endmodule
`default_nettype wire
